// ### design/fdc_params.svh
// constants for the disk controller pin interface block
// assumes one 25 MHz clock and an ahb-lite master in front of it
//
// Summary of operation
// RULE1 - reset: idle state, drive outputs low
// RULE2 - reset keeps step, unload, load times
// RULE3 - ready held at reset: interrupt within 1024ms
// RULE4 - read strobe drives selected register out
// RULE5 - write strobe accepts data bus byte
// RULE6 - strobes honoured only while chip selected
// RULE7 - register select: 1 data, 0 status
// RULE8 - dma request high marks pending transfer
// RULE9 - dma acknowledge low during dma cycle
// RULE10 - terminal count ends read, write, scan
// RULE11 - write clock sets data rate externally; this block has no write clock input
// RULE12 - read data sampled by data window
// RULE13 - oscillator control: 0 inhibit, 1 enable
// RULE14 - density output: 1 double, 0 single
// RULE15 - head select output: 1 head1, 0 head0
// RULE16 - mode output: 1 seek, 0 read/write
// RULE17 - shared input: fault or track zero
// RULE18 - shared input: protect or two side
// RULE19 - shared output: fault reset or step
// RULE20 - shared output: low current or direction
// RULE21 - fault reset pulse before head load
// RULE22 - head load before data access
// RULE23 - mode settles before shared pins reinterpreted
`ifndef FDC_PARAMS_SVH
`define FDC_PARAMS_SVH
// register byte addresses
`define ADDR_CTRL 12'h000
`define ADDR_TIMING 12'h004
`define ADDR_STATUS 12'h008
`define ADDR_DATA 12'h00C
`define ADDR_HOSTREG 12'h010
// control register fields
`define CTRL_GO 0
`define CTRL_CMD_LO 1
`define CTRL_CMD_HI 2
`define CTRL_DENS 3
`define CTRL_HEAD 4
`define CTRL_DIR 5
`define CTRL_LOWCUR 6
`define CTRL_OSC 7
`define CTRL_UNIT_LO 8
`define CTRL_UNIT_HI 9
`define CTRL_DMA 10
`define CTRL_SENSE 11
// command codes in ctrl[2:1]
`define CMD_READ 2'h0
`define CMD_WRITE 2'h1
`define CMD_SCAN 2'h2
`define CMD_SEEK 2'h3
// timing: pulse and settle widths in us, ready-at-reset in ms
`define CLK_MHZ 25
`define FR_PULSE_US 8
`define STEP_PULSE_US 7
`define MODE_SETTLE_US 7
`define FR_CYCLES (`FR_PULSE_US * `CLK_MHZ)
`define STEP_CYCLES (`STEP_PULSE_US * `CLK_MHZ)
`define SETTLE_CYCLES (`MODE_SETTLE_US * `CLK_MHZ)
`define RDY_INT_MS 1024
`define RDY_INT_CYCLES (`RDY_INT_MS * 1000 * `CLK_MHZ)
`define TIMING_RESET 32'h0000_0000
`endif

// ### design/fdc_pkg.sv
// types shared by the disk controller pin interface
// assumes nothing beyond a systemverilog compiler
package fdc_pkg;
    typedef enum logic [2:0] {
        ST_IDLE, ST_SETTLE, ST_FRESET, ST_HLOAD, ST_XFER, ST_STEP
    } seq_state_t;
endpackage

// ### design/disk_controller_pin_interface.sv
// disk controller pin interface: ahb-lite slave, host port, dma, drive pins
// assumes all host, dma and drive inputs are asynchronous to hclk
`timescale 1ns/1ps
`include "fdc_params.svh"
module disk_controller_pin_interface #(
    parameter int unsigned RDY_INT_CYCLES = `RDY_INT_CYCLES
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [11:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic cs_n,
    input wire logic register_select,
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic host_data_bus_oe,
    output logic dma_request,
    input wire logic dma_acknowledge_n,
    input wire logic terminal_count,
    output logic interrupt_req,
    input wire logic index_pulse,
    input wire logic drive_ready,
    input wire logic read_data_window,
    input wire logic read_data_in,
    output logic osc_enable,
    output logic double_density_select,
    output logic head_select,
    output logic [1:0] drive_unit_select,
    output logic seek_mode,
    input wire logic fault_or_track_zero,
    input wire logic protect_or_two_side,
    output logic head_load,
    output logic fault_reset_or_step,
    output logic low_current_or_direction
);
    import fdc_pkg::*;

    localparam int unsigned PULSE_W = 16;
    localparam logic [PULSE_W-1:0] FR_CNT = PULSE_W'(`FR_CYCLES);
    localparam logic [PULSE_W-1:0] STEP_CNT = PULSE_W'(`STEP_CYCLES);
    localparam logic [PULSE_W-1:0] SETTLE_CNT = PULSE_W'(`SETTLE_CYCLES);

    // two-flop synchronisers for every outside input
    logic [11:0] sync1_ff;
    logic [11:0] sync2_ff;
    wire logic [11:0] async_in = {host_data_bus_in[3:0], rd_n, wr_n, cs_n, register_select,
                                  terminal_count, drive_ready, fault_or_track_zero,
                                  protect_or_two_side};
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync1_ff <= 12'h0FF;
            sync2_ff <= 12'h0FF;
        end else begin
            sync1_ff <= async_in;
            sync2_ff <= sync1_ff;
        end
    end
    logic [3:0] dbh1_ff;
    logic [3:0] dbh2_ff;
    logic [3:0] rdin1_ff;
    logic [3:0] rdin2_ff;
    // upper data bits, window, read data, dma ack, index
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dbh1_ff <= 4'h0;
            dbh2_ff <= 4'h0;
            rdin1_ff <= 4'h3;
            rdin2_ff <= 4'h3;
        end else begin
            dbh1_ff <= host_data_bus_in[7:4];
            dbh2_ff <= dbh1_ff;
            rdin1_ff <= {read_data_window, read_data_in, dma_acknowledge_n, ~index_pulse};
            rdin2_ff <= rdin1_ff;
        end
    end
    // no reset: RULE3 reads ready during reset
    logic [1:0] rdy_sync_ff;
    always_ff @(posedge hclk) begin
        rdy_sync_ff <= {rdy_sync_ff[0], drive_ready};
    end
    wire logic [7:0] s_db = {dbh2_ff, sync2_ff[11:8]};
    wire logic s_rd_n = sync2_ff[7];
    wire logic s_wr_n = sync2_ff[6];
    wire logic s_cs_n = sync2_ff[5];
    wire logic s_regsel = sync2_ff[4];
    wire logic s_tc = sync2_ff[3];
    wire logic s_ready = rdy_sync_ff[1];
    wire logic s_fault_or_track_zero = sync2_ff[1];
    wire logic s_protect_or_two_side = sync2_ff[0];
    wire logic s_window = rdin2_ff[3];
    wire logic s_rdd = rdin2_ff[2];
    wire logic s_dma_acknowledge_n_n = rdin2_ff[1];

    // ahb address phase capture
    logic wr_pend_ff;
    logic [11:0] addr_ff;
    wire logic take = hsel & hready & htrans[1];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_ff <= 1'b0;
            addr_ff <= 12'h000;
        end else begin
            wr_pend_ff <= take & hwrite;
            if (take) begin
                addr_ff <= haddr;
            end
        end
    end

    // registers; timing kept through hresetn on purpose
    logic [11:0] ctrl_ff;
    logic [31:0] timing_ff;
    logic timing_init_ff;
    // RULE2 timing survives reset
    always_ff @(posedge hclk) begin
        if (!timing_init_ff) begin
            timing_ff <= `TIMING_RESET;
        end else if (wr_pend_ff && addr_ff == `ADDR_TIMING) begin
            timing_ff <= hwdata;
        end
    end
    // power-on marker; only set, never cleared by hresetn
    always_ff @(posedge hclk) begin
        if (timing_init_ff !== 1'b1) begin
            timing_init_ff <= 1'b1;
        end
    end

    seq_state_t state_ff;
    logic go_pulse;
    logic sense_pulse;
    assign go_pulse = wr_pend_ff && addr_ff == `ADDR_CTRL && hwdata[`CTRL_GO];
    assign sense_pulse = wr_pend_ff && addr_ff == `ADDR_CTRL && hwdata[`CTRL_SENSE];
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_ff <= 12'h000;
        end else if (wr_pend_ff && addr_ff == `ADDR_CTRL && state_ff == ST_IDLE) begin
            ctrl_ff <= {hwdata[11:1], 1'b0};
        end
    end

    // host port data register and latched byte
    logic [7:0] data_reg_ff;
    logic [7:0] host_byte_ff;
    logic host_byte_new_ff;
    logic wr_n_d_ff;
    wire logic host_wr_edge = !s_cs_n && s_wr_n && !wr_n_d_ff;
    // RULE5 byte taken on strobe release
    // RULE6 only while selected
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_n_d_ff <= 1'b1;
            host_byte_ff <= 8'h00;
            host_byte_new_ff <= 1'b0;
        end else begin
            wr_n_d_ff <= s_wr_n | s_cs_n;
            if (host_wr_edge && s_regsel) begin
                host_byte_ff <= s_db;
                host_byte_new_ff <= 1'b1;
            end else if (haddr == `ADDR_HOSTREG && take && !hwrite) begin
                host_byte_new_ff <= 1'b0;
            end
        end
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_reg_ff <= 8'h00;
        end else if (wr_pend_ff && addr_ff == `ADDR_DATA) begin
            data_reg_ff <= hwdata[7:0];
        end
    end

    // sequencer for read/write/seek
    logic [PULSE_W-1:0] cnt_ff;
    logic xfer_done;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_ff <= ST_IDLE;
            cnt_ff <= '0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (go_pulse) begin
                        state_ff <= ST_SETTLE;
                        cnt_ff <= SETTLE_CNT;
                    end
                end
                // RULE23 mode first, then shared pins
                ST_SETTLE: begin
                    if (cnt_ff == '0) begin
                        if (ctrl_ff[`CTRL_CMD_HI:`CTRL_CMD_LO] == `CMD_SEEK) begin
                            state_ff <= ST_STEP;
                            cnt_ff <= STEP_CNT;
                        end else begin
                            state_ff <= ST_FRESET;
                            cnt_ff <= FR_CNT;
                        end
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                // RULE21 fault reset precedes head load
                ST_FRESET: begin
                    if (cnt_ff == '0) begin
                        state_ff <= ST_HLOAD;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                ST_HLOAD: begin
                    state_ff <= ST_XFER;
                end
                // RULE10 terminal count ends transfer
                ST_XFER: begin
                    if (xfer_done) begin
                        state_ff <= ST_IDLE;
                    end
                end
                ST_STEP: begin
                    if (cnt_ff == '0) begin
                        state_ff <= ST_IDLE;
                    end else begin
                        cnt_ff <= cnt_ff - 1'b1;
                    end
                end
                default: begin
                    state_ff <= ST_IDLE;
                end
            endcase
        end
    end
    assign xfer_done = s_tc;

    // RULE12 serial bits caught inside the window
    logic [7:0] shift_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            shift_ff <= 8'h00;
        end else if (state_ff == ST_XFER && s_window) begin
            shift_ff <= {shift_ff[6:0], s_rdd};
        end
    end

    // RULE8 dma request while a dma transfer waits
    // RULE9 acknowledge low completes the cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dma_request <= 1'b0;
        end else begin
            dma_request <= state_ff == ST_XFER && ctrl_ff[`CTRL_DMA] && s_dma_acknowledge_n_n && !s_tc;
        end
    end

    // RULE3 ready seen at reset arms a delayed interrupt
    logic rdy_arm_ff;
    logic [31:0] rdy_cnt_ff;
    logic rdy_seen_ff;
    always_ff @(posedge hclk) begin
        rdy_seen_ff <= !hresetn ? s_ready : 1'b0;
    end
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdy_arm_ff <= 1'b0;
            rdy_cnt_ff <= 32'h0000_0000;
            interrupt_req <= 1'b0;
        end else begin
            if (rdy_seen_ff) begin
                rdy_arm_ff <= 1'b1;
                rdy_cnt_ff <= RDY_INT_CYCLES - 1;
            end else if (rdy_arm_ff) begin
                if (rdy_cnt_ff == 32'h0000_0000) begin
                    rdy_arm_ff <= 1'b0;
                end else begin
                    rdy_cnt_ff <= rdy_cnt_ff - 1'b1;
                end
            end
            // set beats sense-clear in the same cycle
            if (rdy_arm_ff && rdy_cnt_ff == 32'h0000_0000) begin
                interrupt_req <= 1'b1;
            end else if (sense_pulse) begin
                interrupt_req <= 1'b0;
            end
        end
    end

    // drive pins; all low under reset
    // RULE1 outputs to drive reset to 0
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            seek_mode <= 1'b0;
            head_load <= 1'b0;
            fault_reset_or_step <= 1'b0;
            low_current_or_direction <= 1'b0;
            head_select <= 1'b0;
            double_density_select <= 1'b0;
            drive_unit_select <= 2'h0;
            osc_enable <= 1'b0;
        end else begin
            // RULE16 1 seek, 0 read/write
            seek_mode <= ctrl_ff[`CTRL_CMD_HI:`CTRL_CMD_LO] == `CMD_SEEK && state_ff != ST_IDLE;
            // RULE22 head down for data access
            head_load <= state_ff == ST_HLOAD || state_ff == ST_XFER;
            // RULE19 fault reset or step pulse
            fault_reset_or_step <= state_ff == ST_FRESET || state_ff == ST_STEP;
            // RULE20 direction in seek, low current otherwise
            low_current_or_direction <= seek_mode ? ctrl_ff[`CTRL_DIR] : ctrl_ff[`CTRL_LOWCUR];
            // RULE15 head select level
            head_select <= ctrl_ff[`CTRL_HEAD];
            // RULE14 density level
            double_density_select <= ctrl_ff[`CTRL_DENS];
            drive_unit_select <= ctrl_ff[`CTRL_UNIT_HI:`CTRL_UNIT_LO];
            // RULE13 oscillator enable level
            osc_enable <= ctrl_ff[`CTRL_OSC] && state_ff == ST_XFER;
        end
    end

    // RULE17 RULE18 shared inputs split by mode
    logic fault_ff, track0_ff, wprot_ff, two_side_ff;
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fault_ff <= 1'b0;
            track0_ff <= 1'b0;
            wprot_ff <= 1'b0;
            two_side_ff <= 1'b0;
        end else if (state_ff != ST_SETTLE) begin
            if (seek_mode) begin
                track0_ff <= s_fault_or_track_zero;
                two_side_ff <= s_protect_or_two_side;
            end else begin
                fault_ff <= s_fault_or_track_zero;
                wprot_ff <= s_protect_or_two_side;
            end
        end
    end

    // host data bus: RULE4 RULE7 register select picks source
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            host_data_bus_out <= 8'h00;
            host_data_bus_oe <= 1'b0;
        end else begin
            host_data_bus_oe <= !s_cs_n && !s_rd_n && s_wr_n;
            host_data_bus_out <= s_regsel ? data_reg_ff
                                          : {state_ff == ST_IDLE, 2'h0, state_ff != ST_IDLE,
                                             fault_ff, track0_ff, wprot_ff, two_side_ff};
        end
    end

    // ahb read data, registered one cycle after the address phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
        end else if (take && !hwrite) begin
            case (haddr)
                `ADDR_CTRL: hrdata <= {20'h00000, ctrl_ff};
                `ADDR_TIMING: hrdata <= timing_ff;
                `ADDR_STATUS: hrdata <= {20'h00000, shift_ff, interrupt_req, 3'(state_ff)};
                `ADDR_DATA: hrdata <= {24'h000000, data_reg_ff};
                `ADDR_HOSTREG: hrdata <= {23'h000000, host_byte_new_ff, host_byte_ff};
                default: hrdata <= 32'h0000_0000;
            endcase
        end
    end
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
endmodule

// ### tb/fdc_props.sv
// port assertions for the disk controller pin interface
// assumes bind onto the design top, one clock domain
`timescale 1ns/1ps
module fdc_props #(
    parameter int unsigned RDY_INT_CYCLES = 100
) (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic cs_n,
    input wire logic rd_n,
    input wire logic wr_n,
    input wire logic host_data_bus_oe,
    input wire logic dma_request,
    input wire logic terminal_count,
    input wire logic interrupt_req,
    input wire logic drive_ready,
    input wire logic seek_mode,
    input wire logic head_load,
    input wire logic fault_reset_or_step
);
    logic [15:0] fr_cnt_ff;
    logic [15:0] age_ff;
    logic [31:0] cyc_ff;
    logic mode_q_ff;
    logic rdy_ff;
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    // pulse width, mode age, time since reset; ready is latched during reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fr_cnt_ff <= '0;
            age_ff <= '0;
            cyc_ff <= '0;
            mode_q_ff <= 1'b0;
            rdy_ff <= drive_ready;
        end else begin
            fr_cnt_ff <= fault_reset_or_step ? fr_cnt_ff + 16'd1 : 16'd0;
            mode_q_ff <= seek_mode;
            age_ff <= (seek_mode != mode_q_ff) ? 16'd0 : age_ff + {15'd0, age_ff != '1};
            cyc_ff <= cyc_ff + {31'd0, cyc_ff != '1};
        end
    end
    property p_rst_idle;
        $rose(hresetn) |-> !head_load && !seek_mode && !fault_reset_or_step && !dma_request;
    endproperty
    a_rst_idle: assert property (p_rst_idle) else $error("drive pins not low after reset");
    property p_oe_on;
        (!cs_n && !rd_n && wr_n) [*5] |-> host_data_bus_oe;
    endproperty
    a_oe_on: assert property (p_oe_on) else $error("read strobe not driving bus");
    property p_oe_off;
        cs_n [*5] |-> !host_data_bus_oe;
    endproperty
    a_oe_off: assert property (p_oe_off) else $error("bus driven while deselected");
    property p_hl_rw;
        $rose(head_load) |-> !seek_mode;
    endproperty
    a_hl_rw: assert property (p_hl_rw) else $error("head load in seek mode");
    property p_fr_first;
        $rose(head_load) |-> $past(fault_reset_or_step) || $past(fault_reset_or_step, 2);
    endproperty
    a_fr_first: assert property (p_fr_first) else $error("no fault reset before load");
    property p_fr_width;
        $fell(fault_reset_or_step) |-> ($past(seek_mode) ? (fr_cnt_ff >= 16'd150
            && fr_cnt_ff <= 16'd200) : (fr_cnt_ff >= 16'd199 && fr_cnt_ff <= 16'd260));
    endproperty
    a_fr_width: assert property (p_fr_width) else $error("step or reset width off");
    property p_settle;
        $rose(fault_reset_or_step) |-> age_ff > 16'd170;
    endproperty
    a_settle: assert property (p_settle) else $error("pulse too soon after mode");
    property p_tc_end;
        terminal_count [*6] |-> !dma_request;
    endproperty
    a_tc_end: assert property (p_tc_end) else $error("request after count end");
    property p_drq_xfer;
        dma_request |-> head_load && !seek_mode;
    endproperty
    a_drq_xfer: assert property (p_drq_xfer) else $error("request outside transfer");
    property p_rdy_int;
        rdy_ff && cyc_ff == RDY_INT_CYCLES + 8 |-> interrupt_req;
    endproperty
    a_rdy_int: assert property (p_rdy_int) else $error("no ready interrupt");
    c_load: cover property ($rose(head_load));
    c_seek: cover property ($rose(seek_mode));
    c_int_clr: cover property ($fell(interrupt_req));
endmodule
bind disk_controller_pin_interface fdc_props #(.RDY_INT_CYCLES(RDY_INT_CYCLES)) u_props (
    .hclk(hclk), .hresetn(hresetn), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .host_data_bus_oe(host_data_bus_oe), .dma_request(dma_request),
    .terminal_count(terminal_count), .interrupt_req(interrupt_req),
    .drive_ready(drive_ready), .seek_mode(seek_mode), .head_load(head_load),
    .fault_reset_or_step(fault_reset_or_step)
);

// ### tb/drive_dma_model.sv
// drive and dma side stand-in: shared pins, step count, ack handshake
// assumes hclk from the bench and design outputs wired by name
`timescale 1ns/1ps
module drive_dma_model (
    input wire logic hclk,
    input wire logic seek_mode,
    input wire logic fault_reset_or_step,
    input wire logic dma_request,
    output logic dma_acknowledge_n,
    output logic fault_or_track_zero,
    output logic protect_or_two_side,
    output logic drive_ready,
    output logic index_pulse,
    output logic read_data_window,
    output logic read_data_in,
    output logic fault,
    output int steps,
    output int acks
);
    logic fr_q;
    logic [9:0] tick;
    initial begin
        dma_acknowledge_n = 1'b1;
        fault = 1'b1;
        steps = 0;
        acks = 0;
        fr_q = 1'b0;
        tick = 10'h000;
    end
    // a ready drive, so ready stands high through reset
    assign drive_ready = 1'b1;
    // pin meaning follows the mode line; two-sided media
    assign fault_or_track_zero = seek_mode ? (steps == 0) : fault;
    assign protect_or_two_side = seek_mode;
    // loop window and serial data keep moving so stale samples show
    assign read_data_window = tick[1];
    assign read_data_in = tick[2] ^ tick[4];
    assign index_pulse = (tick[9:3] == 7'h00);
    // step and fault-reset edges, dma acknowledge
    always @(posedge hclk) begin
        tick <= tick + 10'h001;
        fr_q <= fault_reset_or_step;
        if (fault_reset_or_step && !fr_q && seek_mode) begin
            steps <= steps + 1;
        end
        if (fault_reset_or_step && !fr_q && !seek_mode) begin
            fault <= 1'b0;
        end
        // ack pulses low for one clock each time request is seen with ack high
        if (dma_request && dma_acknowledge_n) begin
            dma_acknowledge_n <= 1'b0;
            acks <= acks + 1;
        end else begin
            dma_acknowledge_n <= 1'b1;
        end
    end
endmodule

// ### tb/disk_controller_pin_interface_tb.sv
// self-checking bench for the disk controller pin interface
// assumes the checker is bound by its own file
`timescale 1ns/1ps
`include "fdc_params.svh"
module disk_controller_pin_interface_tb;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [11:0] haddr = 12'h000;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata;
    logic hreadyout, hready, hresp, rd_n = 1'b1, wr_n = 1'b1, cs_n = 1'b1;
    logic register_select = 1'b0, terminal_count = 1'b0;
    logic [7:0] host_data_bus_in = 8'h00;
    logic [7:0] host_data_bus_out;
    logic host_data_bus_oe, dma_request, dma_acknowledge_n, interrupt_req, index_pulse;
    logic drive_ready, read_data_window, read_data_in, osc_enable, double_density_select;
    logic head_select, seek_mode, fault_or_track_zero, protect_or_two_side, head_load;
    logic fault_reset_or_step, low_current_or_direction, fault;
    logic [1:0] drive_unit_select;
    logic [31:0] rv;
    int steps, acks, errors = 0, num_checks = 0, cycles = 0;
    assign hready = hreadyout;
    disk_controller_pin_interface #(.RDY_INT_CYCLES(100)) u_dut (.*);
    drive_dma_model u_drive (.*);
    always #20 hclk = ~hclk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // one single ahb transfer; master holds each phase until ready
    task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rv = hrdata;
    endtask
    // bounded wait, then compare the level reached
    task automatic wait_sig(ref logic s, input logic v);
        int n;
        n = 0;
        while (s !== v && n < 2000) begin
            @(posedge hclk);
            n++;
        end
        chk(s, v);
    endtask
    // host strobe cycle; strobes spaced well over four cycles
    task automatic host(input logic wr, input logic sel, input logic ncs, input logic [7:0] d);
        @(posedge hclk);
        cs_n <= ncs;
        register_select <= sel;
        host_data_bus_in <= d;
        @(posedge hclk);
        wr_n <= !wr;
        rd_n <= wr;
        repeat (6) @(posedge hclk);
        rv = {23'h0, host_data_bus_oe, host_data_bus_out};
        wr_n <= 1'b1;
        rd_n <= 1'b1;
        repeat (2) @(posedge hclk);
        cs_n <= 1'b1;
        repeat (5) @(posedge hclk);
    endtask
    task automatic idle_wait();
        repeat (60) begin
            ahb(1'b0, `ADDR_STATUS, 32'h0);
            if (rv[2:0] === 3'h0) break;
        end
        chk(rv[2:0], 3'h0);
    endtask
    task automatic t_reset();
        @(posedge hclk);
        chk({head_load, seek_mode, fault_reset_or_step, low_current_or_direction}, 0);
        ahb(1'b1, `ADDR_TIMING, 32'h0000_3A5C);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `ADDR_TIMING, 32'h0);
        chk(rv, 32'h0000_3A5C);
        ahb(1'b0, 12'h020, 32'h0);
        chk(rv, 32'h0);
        $display("reset test done");
    endtask
    task automatic t_int();
        wait_sig(interrupt_req, 1'b1);
        repeat (10) @(posedge hclk);
        ahb(1'b1, `ADDR_CTRL, 32'h1 << `CTRL_SENSE);
        repeat (3) @(posedge hclk);
        chk(interrupt_req, 0);
        $display("interrupt test done");
    endtask
    task automatic t_pins();
        int bits[4] = '{`CTRL_DENS, `CTRL_HEAD, `CTRL_OSC, `CTRL_UNIT_LO};
        for (int i = 0; i < 4; i++) begin
            ahb(1'b1, `ADDR_CTRL, 32'h1 << bits[i]);
            repeat (2) @(posedge hclk);
            chk({double_density_select, head_select, osc_enable, drive_unit_select[0]},
                (4'h8 >> i) & 4'hD);
        end
        ahb(1'b1, `ADDR_CTRL, 32'h0);
        $display("pin level test done");
    endtask
    task automatic t_rw();
        int cmds[3] = '{`CMD_READ, `CMD_WRITE, `CMD_SCAN};
        int a0;
        foreach (cmds[i]) begin
            a0 = acks;
            ahb(1'b1, `ADDR_CTRL, 32'h4C1 | (cmds[i] << 1));
            wait_sig(head_load, 1'b1);
            chk({fault, seek_mode, low_current_or_direction}, 3'h1);
            wait_sig(dma_request, 1'b1);
            repeat (8) @(posedge hclk);
            chk({acks > a0, osc_enable}, 2'h3);
            terminal_count <= 1'b1;
            wait_sig(dma_request, 1'b0);
            idle_wait();
            terminal_count <= 1'b0;
        end
        $display("transfer test done");
    endtask
    task automatic t_seek();
        int s0;
        s0 = steps;
        ahb(1'b1, `ADDR_CTRL, 32'h27);
        wait_sig(seek_mode, 1'b1);
        wait_sig(fault_reset_or_step, 1'b1);
        chk(low_current_or_direction, 1);
        idle_wait();
        chk(steps, s0 + 1);
        $display("seek test done");
    endtask
    task automatic t_host();
        host(1'b1, 1'b1, 1'b1, 8'hA5);
        ahb(1'b0, `ADDR_HOSTREG, 32'h0);
        chk(rv[8:0], 9'h000);
        host(1'b1, 1'b1, 1'b0, 8'h3C);
        ahb(1'b0, `ADDR_HOSTREG, 32'h0);
        chk(rv[8:0], 9'h13C);
        ahb(1'b1, `ADDR_DATA, 32'h5A);
        host(1'b0, 1'b1, 1'b0, 8'h00);
        chk(rv[8:0], 9'h15A);
        host(1'b0, 1'b0, 1'b0, 8'h00);
        chk(rv[8:0], 9'h181);
        host(1'b0, 1'b1, 1'b1, 8'h00);
        chk(rv[8], 1'b0);
        $display("host port test done");
    endtask
    task automatic finish_test();
        $display("checks %0d mismatches %0d", num_checks, errors);
        if (errors == 0 && num_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    // hang guard, well past the longest expected run
    always @(posedge hclk) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_int();
        t_pins();
        t_rw();
        t_seek();
        t_host();
        finish_test();
    end
endmodule
